// >>> common/swt_pkg.sv
// stop-mode wake-up timer: constants, register layout and state types
// assumes one 40 MHz clock; the 32 kHz ring oscillator rate is made by a divider
// How it works
// R1: ten-bit up counter, terminal count all ones
// R2: counts only while the cpu is stopped
// R3: clocked from 32 kHz ring tick via prescaler
// R4: reaching 3FF raises the wake-up event
// R5: keeps counting after halt until 3FF
// R6: cpu resumes after stop once handler returns
// R7: reset loads control register with zero
// R8: bit 7 enables, zero disables the timer
// R9: bit 5 gates the terminal-count interrupt request
// R10: software keeps prescale code at most 12
// R11: code zero is 2048 ring cycles, doubling
// R12: software enables ring oscillator, then timer, prescale
// R13: software stops immediately after enabling the timer
// R14: handler disables interrupt then returns at once
// R15: enable restarts count at zero; hold while off
package swt_pkg;

  localparam logic [7:0]  SWT_CTRL_ADDR    = 8'hfa;
  localparam logic [7:0]  SWT_CTRL_RESET   = 8'h00;
  localparam int          SWT_EN_BIT       = 7;
  localparam int          SWT_DONE_BIT     = 6;
  localparam int          SWT_IE_BIT       = 5;
  localparam int          SWT_CNT_W        = 10;
  localparam logic [9:0]  SWT_TERMINAL     = 10'h3ff;
  localparam logic [3:0]  SWT_PS_MAX       = 4'hc;

  localparam int          SWT_CLK_HZ       = 40_000_000;
  localparam int          SWT_RING_HZ      = 32_000;
  // ring period rounded down to whole clock cycles
  localparam int          SWT_RING_DIV     = SWT_CLK_HZ / SWT_RING_HZ;
  localparam int          SWT_RING_W       = 11;
  // ring cycles per counter step at code 0: 2048 cycles over 1024 steps
  localparam int          SWT_PS_BASE      = 2048 / (1 << SWT_CNT_W);
  localparam int          SWT_PS_W         = 13;

  typedef struct packed {
    logic       enable;
    logic       done;
    logic       int_en;
    logic       spare;
    logic [3:0] wake_prescale_select;
  } swt_ctrl_t;

  typedef enum logic [2:0] {
    SWT_OFF  = 3'b001,
    SWT_RUN  = 3'b010,
    SWT_DONE = 3'b100
  } swt_state_t;

endpackage : swt_pkg

// >>> src/swt_prescaler.sv
// ring-oscillator tick and prescale divider for the wake-up counter
// assumes run is a level from the same clock domain
`timescale 1ns/1ps
module swt_prescaler
  import swt_pkg::*;
#(
  // ring period in clk cycles; a smaller value shortens simulation only
  parameter int RING_DIV = SWT_RING_DIV
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [3:0] prescale_code,
  output logic            step
);

  logic [SWT_RING_W-1:0] ring_cnt;
  logic [SWT_RING_W-1:0] next_ring_cnt;
  logic [SWT_PS_W-1:0]   pre_cnt;
  logic [SWT_PS_W-1:0]   next_pre_cnt;
  logic [SWT_PS_W-1:0]   pre_limit;
  logic [3:0]            code;
  logic                  ring_tick;

  always_comb begin
    // invalid codes above 12 are clamped to the slowest legal rate
    code          = (prescale_code > SWT_PS_MAX) ? SWT_PS_MAX : prescale_code;
    pre_limit     = SWT_PS_W'((SWT_PS_BASE << code) - 1); // R11
    ring_tick     = run && (ring_cnt == SWT_RING_W'(RING_DIV - 1)); // R3
    next_ring_cnt = ring_cnt;
    next_pre_cnt  = pre_cnt;
    step          = 1'b0;
    if (!run) begin
      next_ring_cnt = '0;
      next_pre_cnt  = '0;
    end else if (ring_tick) begin
      next_ring_cnt = '0;
      if (pre_cnt >= pre_limit) begin
        next_pre_cnt = '0;
        step         = 1'b1;
      end else begin
        next_pre_cnt = pre_cnt + 1'b1;
      end
    end else begin
      next_ring_cnt = ring_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ring_cnt <= '0;
      pre_cnt  <= '0;
    end else begin
      ring_cnt <= next_ring_cnt;
      pre_cnt  <= next_pre_cnt;
    end
  end

endmodule : swt_prescaler

// >>> src/swt_top.sv
// stop-mode wake-up timer: control register, 10-bit counter, wake request
// assumes the cpu register port is synchronous to clk, one access per cycle
`timescale 1ns/1ps
module swt_top
  import swt_pkg::*;
#(
  parameter int RING_DIV = SWT_RING_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  input  wire logic                 stop_mode,
  input  wire logic                 ring_osc_on,
  output logic                      wake_irq,
  output logic                      wake_event,
  output logic [SWT_CNT_W-1:0]      wake_count
);

  swt_ctrl_t            ctrl;
  swt_ctrl_t            next_ctrl;
  swt_state_t           state;
  swt_state_t           next_state;
  logic [SWT_CNT_W-1:0] count;
  logic [SWT_CNT_W-1:0] next_count;
  logic                 next_wake_irq;
  logic                 next_wake_event;
  logic [7:0]           next_rdata;
  logic                 ctrl_wr;
  logic                 en_rise;
  logic                 run;
  logic                 step;

  // control register
  always_comb begin
    ctrl_wr   = reg_wr && (reg_addr == SWT_CTRL_ADDR);
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.enable               = reg_wdata[SWT_EN_BIT]; // R8
      next_ctrl.int_en               = reg_wdata[SWT_IE_BIT]; // R9
      next_ctrl.wake_prescale_select = reg_wdata[3:0];
    end
    next_ctrl.spare = 1'b0;
    next_ctrl.done  = (state == SWT_DONE);
    en_rise         = ctrl_wr && reg_wdata[SWT_EN_BIT] && !ctrl.enable;
    next_rdata      = (reg_addr == SWT_CTRL_ADDR) ? 8'(ctrl) : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl      <= swt_ctrl_t'(SWT_CTRL_RESET); // R7
      reg_rdata <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      reg_rdata <= next_rdata;
    end
  end

  // counter runs only in stop mode with the oscillator on
  assign run = ctrl.enable && stop_mode && ring_osc_on && (state == SWT_RUN) && !en_rise; // R2

  swt_prescaler #(.RING_DIV(RING_DIV)) u_prescaler (
    .clk           (clk),
    .rst           (rst),
    .run           (run),
    .prescale_code (ctrl.wake_prescale_select),
    .step          (step)
  );

  always_comb begin
    next_state      = state;
    next_count      = count;
    next_wake_irq   = 1'b0;
    next_wake_event = 1'b0;
    case (state)
      SWT_OFF: begin
        if (next_ctrl.enable) begin
          next_state = SWT_RUN;
          next_count = '0; // R15
        end
      end
      SWT_RUN: begin
        if (!next_ctrl.enable) begin
          next_state = SWT_OFF; // R15
        end else if (en_rise) begin
          next_count = '0;
        end else if (step) begin
          next_count = count + 1'b1; // R1 R5
          if (count + 1'b1 == SWT_TERMINAL) begin
            next_state      = SWT_DONE;
            next_wake_event = 1'b1; // R4
            // gate with the value the control register holds when the pulse shows
            next_wake_irq   = next_ctrl.int_en; // R9
          end
        end
      end
      SWT_DONE: begin
        // holds at terminal count until software disables; writing enable again while enabled does not leave this state
        if (!next_ctrl.enable) begin
          next_state = SWT_OFF;
        end
      end
      default: begin
        next_state = SWT_OFF;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= SWT_OFF;
      count      <= '0;
      wake_irq   <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      state      <= next_state;
      count      <= next_count;
      wake_irq   <= next_wake_irq; // R6
      wake_event <= next_wake_event;
    end
  end

  assign wake_count = count;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_irq_cause;
    wake_irq |-> wake_event && ctrl.int_en && count == SWT_TERMINAL;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause"); // R9

  property p_event_at_terminal;
    wake_event |-> count == SWT_TERMINAL && $past(count) == SWT_TERMINAL - 10'h001;
  endproperty
  a_event_at_terminal: assert property (p_event_at_terminal) // R4
    else $error("wake event not at terminal count");

  property p_terminal_event;
    (state == SWT_RUN && step && count == SWT_TERMINAL - 10'h001 && !ctrl_wr)
      |=> wake_event ##1 !wake_event;
  endproperty
  a_terminal_event: assert property (p_terminal_event) // R1
    else $error("terminal count missed");

  property p_no_run_count;
    (!stop_mode && !en_rise && state != SWT_OFF) |=> $stable(count);
  endproperty
  a_no_run_count: assert property (p_no_run_count) else $error("counted outside stop"); // R2

  property p_enable_clears;
    en_rise |=> count == '0 && ctrl.enable;
  endproperty
  a_enable_clears: assert property (p_enable_clears) else $error("enable did not clear"); // R15

  property p_hold_off;
    (!ctrl.enable && !ctrl_wr) |=> $stable(count) && !wake_event;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while disabled"); // R15

  property p_hold_done;
    (state == SWT_DONE && !ctrl_wr) |=> (count == SWT_TERMINAL) [*2];
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("terminal not held"); // R5

  property p_write_en;
    ctrl_wr |=> ctrl.enable == $past(reg_wdata[SWT_EN_BIT])
      && ctrl.int_en == $past(reg_wdata[SWT_IE_BIT]);
  endproperty
  a_write_en: assert property (p_write_en) else $error("control write lost"); // R8

  property p_step_slow;
    step |=> !step [*8];
  endproperty
  a_step_slow: assert property (p_step_slow) else $error("steps too close"); // R3

  c_wake_irq:   cover property (wake_irq);
  c_wake_noirq: cover property (wake_event && !ctrl.int_en);
  c_rearm:      cover property (state == SWT_DONE ##1 en_rise);

endmodule : swt_top

// >>> testbench/stop_mode_wakeup_timer_bench.sv
// bench for swt_top: register port, stop-mode counting, restart and hold
// assumes a 40 MHz clk and inputs driven at the falling edge
`timescale 1ns/1ps
module stop_mode_wakeup_timer_bench;
  import swt_pkg::*;
  // short ring period so a full count to terminal fits in the run
  localparam int        BENCH_RING_DIV = 5;
  // code 0: 2048 ring cycles over 1024 steps
  localparam int        STEP_CLK       = BENCH_RING_DIV * 2048 / 1024;
  logic                 clk         = 1'b0;
  logic                 rst         = 1'b1;
  logic                 reg_wr      = 1'b0;
  logic                 stop_mode   = 1'b0;
  logic                 ring_osc_on = 1'b0;
  logic [7:0]           reg_addr    = 8'h00;
  logic [7:0]           reg_wdata   = 8'h00;
  logic [7:0]           reg_rdata;
  logic [7:0]           rd;
  logic [7:0]           d;
  logic                 wake_irq;
  logic                 wake_event;
  logic [SWT_CNT_W-1:0] wake_count;
  int                   failures    = 0;
  int                   check_count = 0;
  int                   seed        = 45;
  int                   mdl_cnt     = 0;
  int                   gap;
  int                   code;

  always #12.5 clk = ~clk;

  swt_top #(.RING_DIV(BENCH_RING_DIV)) i_swt_top (
    .clk        (clk),
    .rst        (rst),
    .reg_addr   (reg_addr),
    .reg_wr     (reg_wr),
    .reg_wdata  (reg_wdata),
    .reg_rdata  (reg_rdata),
    .stop_mode  (stop_mode),
    .ring_osc_on(ring_osc_on),
    .wake_irq   (wake_irq),
    .wake_event (wake_event),
    .wake_count (wake_count)
  );

  task report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task cmp_num(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_num

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task rdr(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    v = reg_rdata;
  endtask : rdr

  // syncs to one counter step, then counts clocks to the next one
  task gap_of(output int n);
    logic [9:0] c;
    int         k;
    c = wake_count;
    k = 0;
    while (wake_count === c && k < 12000) begin
      @(negedge clk);
      k++;
    end
    c = wake_count;
    n = 0;
    while (wake_count === c && n < 12000) begin
      @(negedge clk);
      n++;
    end
    mdl_cnt += 2;
  endtask : gap_of

  task hold_chk;
    repeat (3000) @(negedge clk);
    cmp_num(wake_count, mdl_cnt);
  endtask : hold_chk

  // enable from off, stop at once, count clocks to the wake pulse
  task wake_run(input logic ie);
    int n;
    n = 0;
    stop_mode = 1'b0;
    wr(SWT_CTRL_ADDR, 8'h00);
    wr(SWT_CTRL_ADDR, {1'b1, 1'b0, ie, 5'h00});
    stop_mode = 1'b1;
    while (wake_event !== 1'b1 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    cmp_num(n, 1023 * STEP_CLK);
    cmp_num(wake_count, SWT_TERMINAL);
    cmp_num(wake_irq, ie);
    @(negedge clk);
    cmp_num({wake_event, wake_irq}, 0);
    cmp_num(wake_count, SWT_TERMINAL);
    rdr(SWT_CTRL_ADDR, rd);
    cmp_reg(rd, {1'b1, 1'b1, ie, 5'h00});
    wr(SWT_CTRL_ADDR, rd & 8'h0f);
    stop_mode = 1'b0;
    cmp_num(wake_count, SWT_TERMINAL);
  endtask : wake_run

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rdr(SWT_CTRL_ADDR, rd);
    cmp_reg(rd, SWT_CTRL_RESET);
    cmp_num(wake_count, 0);
    ring_osc_on = 1'b1;
    // bits 6 and 4 written at random must be ignored
    d = 8'ha0 | (8'($random(seed)) & 8'h50);
    wr(SWT_CTRL_ADDR, d);
    rdr(SWT_CTRL_ADDR, rd);
    cmp_reg(rd, 8'ha0);
    rdr(8'hf9, rd);
    cmp_reg(rd, 8'h00);
    hold_chk();
    stop_mode = 1'b1;
    gap_of(gap);
    cmp_num(gap, STEP_CLK);
    cmp_num(wake_count, mdl_cnt);
    ring_osc_on = 1'b0;
    hold_chk();
    ring_osc_on = 1'b1;
    stop_mode   = 1'b0;
    hold_chk();
    stop_mode = 1'b1;
    wr(SWT_CTRL_ADDR, 8'h20);
    hold_chk();
    rdr(SWT_CTRL_ADDR, rd);
    cmp_reg(rd, 8'h20);
    code = 1 + ($random(seed) & 1);
    wr(SWT_CTRL_ADDR, 8'ha0 | 8'(code));
    mdl_cnt = 0;
    cmp_num(wake_count, mdl_cnt);
    gap_of(gap);
    cmp_num(gap, STEP_CLK << code);
    cmp_num(wake_count, mdl_cnt);
    wr(SWT_CTRL_ADDR, 8'ha0 | 8'(code));
    cmp_num(wake_count, mdl_cnt);
    cmp_num({wake_event, wake_irq}, 0);
    wake_run(1'b1);
    wake_run(1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdr(SWT_CTRL_ADDR, rd);
    cmp_reg(rd, SWT_CTRL_RESET);
    cmp_num(wake_count, 0);
    report_and_stop();
  end

  initial begin
    #(25 * 80000);
    failures++;
    report_and_stop();
  end
endmodule : stop_mode_wakeup_timer_bench
